// ===== core/adc_cfg.svh
// timing, reset and coding constants for the converter control port
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// system clock period
`define CLK_PERIOD_NS 50
// least acquisition time after each conversion
`define ACQ_TIME_NS 1000
// internal conversion time
`define CONV_TIME_NS 8000
// both are least times, so round up to whole cycles
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half period of the internally made serial clock, in cycles
`define SCLK_HALF_CYCLES 2
// result width and top bit
`define RESULT_BITS 16
`define RESULT_MSB 15
// xor mask turning straight binary into two's complement
`define MIDSCALE_FLIP 16'h8000
// pin synchroniser reset: active-low pins idle high
`define PIN_RESET 9'h007

`endif

// ===== core/adc_pkg.sv
// shared types of the converter control port
package adc_pkg;
	// conversion result word
	typedef logic [15:0] word_t;
	// phase timer
	typedef logic [7:0] count_t;
	// serial bit counter, 0 to 16
	typedef logic [4:0] bitcnt_t;
	// control phases, gray coded along acquire, wait, convert
	typedef enum logic [1:0] {
		ACQ_ST = 2'b00,
		WAIT_ST = 2'b01,
		CONV_ST = 2'b11,
		PWRDN_ST = 2'b10
	} conv_state_e;
endpackage

// ===== core/shift_if.sv
// link between the control logic and the result shift register
`timescale 1ns/10ps
interface shift_if;
	logic load; // take a fresh result, drops any old one
	logic shift; // move one bit out
	adc_pkg::word_t load_data; // result to be shifted
	logic bit_out; // current serial bit
	adc_pkg::bitcnt_t bits_left; // bits not yet shifted
	logic mid_read; // read started but not finished
	modport ctrl(output load, shift, load_data,
		input bit_out, bits_left, mid_read);
	modport shft(input load, shift, load_data,
		output bit_out, bits_left, mid_read);
endinterface

// ===== core/result_shifter.sv
// serial result shift register, msb first
`timescale 1ns/10ps
`include "adc_cfg.svh"
module result_shifter (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control side
	shift_if.shft sh
);
	import adc_pkg::*;

	word_t sr_reg; // bits still to go, top bit on the pin
	bitcnt_t left_reg; // how many remain

	////////////////////////////////////////////////////////////////////
	// load beats shift so stale data never mixes with new
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sr_reg <= '0;
			left_reg <= '0;
		end else if (sh.load) begin
			sr_reg <= sh.load_data;
			left_reg <= bitcnt_t'(`RESULT_BITS);
		end else if (sh.shift && left_reg != '0) begin
			sr_reg <= {sr_reg[`RESULT_MSB-1:0], 1'b0};
			left_reg <= left_reg - bitcnt_t'(1);
		end
	end

	assign sh.bit_out = sr_reg[`RESULT_MSB];
	assign sh.bits_left = left_reg;
	assign sh.mid_read = left_reg != '0 &&
		left_reg != bitcnt_t'(`RESULT_BITS);

	////////////////////////////////////////////////////////////////////
	// each shift brings the next lower bit to the pin
	property p_msb_first;
		@(posedge clk) disable iff (!rstn)
		(sh.shift && !sh.load && left_reg != '0) |=>
			sh.bit_out == $past(sr_reg[`RESULT_MSB-1]);
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("serial bit order broken");
endmodule

// ===== core/adc_control.sv
// conversion control and result read-out of the converter
`timescale 1ns/10ps
`include "adc_cfg.svh"
module adc_control (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// host pins, asynchronous to clk
	input wire logic convert_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic reset,
	input wire logic power_down,
	input wire logic output_coding_select,
	input wire logic serial_parallel_select,
	input wire logic external_clock_select,
	input wire logic sclk_in,
	// comparator code from the analog core, same clock
	input wire adc_pkg::word_t sar_code,
	// converter status
	output logic busy,
	output logic sample_hold,
	output logic low_power,
	// parallel result bus
	output adc_pkg::word_t data_out,
	output logic data_oe,
	// serial port
	output logic serial_result_out,
	output logic serial_oe,
	output logic sclk_out,
	output logic sclk_oe,
	output logic sync_out,
	output logic incomplete_read_flag
);
	import adc_pkg::*;

	localparam int PIN_N = 9;
	localparam logic [PIN_N-1:0] PIN_RST = `PIN_RESET;
	localparam int CONV_LAST = `CONV_CYCLES - 1;
	localparam logic [1:0] HALF_LAST = 2'(`SCLK_HALF_CYCLES - 1);

	// straight binary when select is high, else two's complement
	function automatic word_t code_fmt(input word_t raw, input logic bin);
		code_fmt = bin ? raw : raw ^ `MIDSCALE_FLIP;
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PIN_N-1:0] pin_raw; // pins as they arrive
	logic [PIN_N-1:0] pin_meta; // first stage, read only by second
	logic [PIN_N-1:0] pin_sync; // safe to use
	assign pin_raw = {sclk_in, external_clock_select,
		serial_parallel_select, output_coding_select, power_down,
		reset, rd_n, cs_n, convert_start_n};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_sync
			// two flops per pin against metastability
			always_ff @(posedge clk) begin
				if (!rstn) begin
					pin_meta[gi] <= PIN_RST[gi];
					pin_sync[gi] <= PIN_RST[gi];
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic cnv_n_s, cs_n_s, rd_n_s, abort_s, pd_s;
	logic coding_s, serial_s, ext_s, sclk_s;
	assign {sclk_s, ext_s, serial_s, coding_s, pd_s, abort_s, rd_n_s,
		cs_n_s, cnv_n_s} = pin_sync;

	////////////////////////////////////////////////////////////////////
	// edge detection on start and external serial clock
	logic cnv_prev_reg; // start level one cycle ago
	logic sclk_prev_reg; // serial clock level one cycle ago
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnv_prev_reg <= 1'b1;
			sclk_prev_reg <= 1'b0;
		end else begin
			cnv_prev_reg <= cnv_n_s;
			sclk_prev_reg <= sclk_s;
		end
	end
	logic cnv_fall, sclk_rise;
	assign cnv_fall = cnv_prev_reg && !cnv_n_s;
	assign sclk_rise = !sclk_prev_reg && sclk_s;

	////////////////////////////////////////////////////////////////////
	// conversion sequencer
	conv_state_e state_reg, state_next;
	count_t timer_reg; // cycles left in acquire or convert
	logic conv_done; // last cycle of a conversion
	assign conv_done = state_reg == CONV_ST && timer_reg == '0;

	// next phase; start edges only matter outside conversion
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ACQ_ST: begin
				if (timer_reg == '0) begin
					if (pd_s)
						state_next = PWRDN_ST;
					else if (!cnv_n_s)
						state_next = CONV_ST;
					else
						state_next = WAIT_ST;
				end
			end
			WAIT_ST: begin
				if (pd_s)
					state_next = PWRDN_ST;
				else if (cnv_fall)
					state_next = CONV_ST;
			end
			CONV_ST: begin
				// power down waits for the end; start edges ignored
				if (conv_done)
					state_next = ACQ_ST;
			end
			PWRDN_ST: begin
				if (!pd_s)
					state_next = ACQ_ST;
			end
			default: state_next = ACQ_ST;
		endcase
	end

	// phase register and internal timer; reset pin aborts at once
	always_ff @(posedge clk) begin
		if (!rstn || abort_s) begin
			state_reg <= ACQ_ST;
			timer_reg <= count_t'(`ACQ_CYCLES - 1);
		end else begin
			state_reg <= state_next;
			if (state_next == CONV_ST && state_reg != CONV_ST)
				timer_reg <= count_t'(`CONV_CYCLES - 1);
			else if (state_next == ACQ_ST && state_reg != ACQ_ST)
				timer_reg <= count_t'(`ACQ_CYCLES - 1);
			else if (timer_reg != '0)
				timer_reg <= timer_reg - count_t'(1);
		end
	end

	// status flops so the pins never glitch on state decode
	always_ff @(posedge clk) begin
		if (!rstn || abort_s) begin
			busy <= 1'b0;
			low_power <= 1'b0;
		end else begin
			busy <= state_next == CONV_ST;
			low_power <= state_next == PWRDN_ST;
		end
	end
	assign sample_hold = busy; // held for the whole conversion

	////////////////////////////////////////////////////////////////////
	// result latch and parallel bus
	always_ff @(posedge clk) begin
		if (!rstn)
			data_out <= '0;
		else if (conv_done && !abort_s)
			data_out <= code_fmt(sar_code, coding_s);
	end

	logic rd_en; // select and read both low
	assign rd_en = !cs_n_s && !rd_n_s;
	assign data_oe = rd_en && !serial_s;
	assign serial_oe = rd_en && serial_s;

	////////////////////////////////////////////////////////////////////
	// serial port: shift register and clocking
	shift_if sh ();
	result_shifter u_shifter (
		.clk(clk),
		.rstn(rstn),
		.sh(sh.shft)
	);

	logic int_active; // master mode read in progress
	logic [1:0] div_reg; // internal clock divider
	logic int_fall; // internal clock about to fall
	assign int_active = serial_s && !ext_s && rd_en && sh.bits_left != '0;
	assign int_fall = int_active && sclk_out && div_reg == HALF_LAST;

	// divider making the serial clock in master mode; idles low
	always_ff @(posedge clk) begin
		if (!rstn || !int_active) begin
			div_reg <= '0;
			sclk_out <= 1'b0;
		end else if (div_reg == HALF_LAST) begin
			div_reg <= '0;
			sclk_out <= !sclk_out;
		end else begin
			div_reg <= div_reg + 2'(1);
		end
	end
	assign sclk_oe = serial_s && !ext_s;

	// frame marker while master-mode data is valid
	always_ff @(posedge clk) begin
		if (!rstn)
			sync_out <= 1'b0;
		else
			sync_out <= int_active;
	end

	// external clock counts only while selected
	assign sh.load = conv_done && !abort_s;
	assign sh.load_data = code_fmt(sar_code, coding_s);
	assign sh.shift = (serial_s && ext_s && !cs_n_s && sclk_rise)
		|| int_fall;
	assign serial_result_out = sh.bit_out;

	// slave read caught mid-word by a new result: flag one cycle
	always_ff @(posedge clk) begin
		if (!rstn || abort_s)
			incomplete_read_flag <= 1'b0;
		else
			incomplete_read_flag <= sh.load && serial_s && ext_s &&
				sh.mid_read;
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_busy_len;
		@(posedge clk) disable iff (!rstn || abort_s)
		$rose(busy) |-> ##CONV_LAST busy ##1 !busy;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("conversion length wrong");

	property p_busy_end;
		@(posedge clk) disable iff (!rstn)
		($fell(busy) && !$past(abort_s)) |-> $past(sh.load);
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("busy fell without result latch");

	property p_bus_gate;
		@(posedge clk) disable iff (!rstn)
		(data_oe || serial_oe) |-> (!cs_n_s && !rd_n_s);
	endproperty
	a_bus_gate: assert property (p_bus_gate)
		else $error("output bus enabled without select and read");

	property p_clk_gate;
		@(posedge clk) disable iff (!rstn)
		(serial_s && ext_s && cs_n_s) |-> !sh.shift;
	endproperty
	a_clk_gate: assert property (p_clk_gate)
		else $error("external clock shifted while deselected");

	property p_abort;
		@(posedge clk) disable iff (!rstn)
		abort_s |=> (!busy && state_reg == ACQ_ST);
	endproperty
	a_abort: assert property (p_abort)
		else $error("reset did not abort");

	property p_pd_finish;
		@(posedge clk) disable iff (!rstn || abort_s)
		(busy && pd_s && timer_reg > 8'h01) |=> busy;
	endproperty
	a_pd_finish: assert property (p_pd_finish)
		else $error("power down cut a conversion short");

	property p_pd_block;
		@(posedge clk) disable iff (!rstn || abort_s)
		(state_reg == PWRDN_ST && pd_s) |=> (!busy && low_power);
	endproperty
	a_pd_block: assert property (p_pd_block)
		else $error("conversion started in power down");

	property p_wait_edge;
		@(posedge clk) disable iff (!rstn || abort_s)
		(state_reg == WAIT_ST) |=> (busy == $past(cnv_fall && !pd_s));
	endproperty
	a_wait_edge: assert property (p_wait_edge)
		else $error("start edge handling wrong");

	property p_level_start;
		@(posedge clk) disable iff (!rstn || abort_s)
		(state_reg == ACQ_ST && timer_reg == '0 && !cnv_n_s && !pd_s)
			|=> busy;
	endproperty
	a_level_start: assert property (p_level_start)
		else $error("held-low start did not convert");

	property p_coding;
		@(posedge clk) disable iff (!rstn || abort_s)
		conv_done |=> (data_out ^ $past(sar_code)) ==
			($past(coding_s) ? 16'h0000 : `MIDSCALE_FLIP);
	endproperty
	a_coding: assert property (p_coding)
		else $error("output coding wrong");

	property p_rd_flag;
		@(posedge clk) disable iff (!rstn || abort_s)
		(sh.load && serial_s && ext_s && sh.mid_read) |=>
			incomplete_read_flag ##1 !incomplete_read_flag;
	endproperty
	a_rd_flag: assert property (p_rd_flag)
		else $error("incomplete read not flagged");

	property p_no_restart;
		@(posedge clk) disable iff (!rstn || abort_s)
		(state_reg == CONV_ST && cnv_fall && timer_reg != '0) |=>
			(state_reg == CONV_ST && timer_reg == $past(timer_reg) - 8'h01);
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("start edge disturbed a conversion");
endmodule

// ===== testbench/host_model.sv
// host controller model driving the converter control pins
`timescale 1ns/10ps
module host_model (
	// clock
	input wire logic clk,
	// converter status seen by the host
	input wire logic busy,
	// host pins
	output logic convert_start_n,
	output logic cs_n,
	output logic rd_n,
	output logic reset,
	output logic power_down,
	output logic sclk_in
);
	////////////////////////////////////////
	// idle levels: active-low pins high, the rest low
	initial begin
		convert_start_n = 1'b1;
		cs_n = 1'b1;
		rd_n = 1'b1;
		reset = 1'b0;
		power_down = 1'b0;
		sclk_in = 1'b0;
	end
	////////////////////////////////////////
	// step to just after a rising edge, so pins never race the clock
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// clean falling edge, held low until busy shows or 8 cycles pass
	task automatic start_pulse();
		int n;
		n = 0;
		convert_start_n = 1'b0;
		do begin
			tick(1);
			n++;
		end while (busy !== 1'b1 && n < 8);
		convert_start_n = 1'b1;
	endtask
	// level drive of start, for the held-low start case
	task automatic set_start(input logic v);
		convert_start_n = v;
	endtask
	// busy fall taken as data ready; returns cycles waited, bounded
	task automatic wait_ready(output int len);
		len = 0;
		while (busy === 1'b1 && len < 400) begin
			tick(1);
			len++;
		end
	endtask
	// select and read, given time to pass the pin synchroniser
	task automatic set_sel(input logic c, input logic r);
		cs_n = c;
		rd_n = r;
		tick(3);
	endtask
	// abort and power-down pins
	task automatic pins(input logic r, input logic p);
		reset = r;
		power_down = p;
		tick(4);
	endtask
	// one external clock, high and low each longer than two cycles
	task automatic sclk_pulse();
		sclk_in = 1'b1;
		tick(4);
		sclk_in = 1'b0;
		tick(4);
	endtask
endmodule

// ===== testbench/tb_adc_conversion_control_port.sv
// self-checking bench of the converter control port
`timescale 1ns/10ps
module tb_adc_conversion_control_port;
	import adc_pkg::*;
	////////////////////////////////////////
	logic clk = 1'b0; // 20 mhz system clock
	logic rstn; // synchronous reset, active low
	logic coding; // high selects straight binary
	logic ser; // high selects the serial port
	logic ext; // high selects the external serial clock
	word_t code; // comparator code fed to the core
	logic cnv_n, cs_n, rd_n, rst_pin, pd, sclk; // host pins
	logic busy, lowp, doe, sdo, soe, flag; // watched outputs
	logic hold, sclk_o, sclk_en, sync_o; // hold and serial clocking outputs
	logic sclk_last; // internal serial clock at the previous look
	int n_bits; // bits taken in master mode
	word_t dout; // parallel result
	int n_fail = 0; // mismatches seen
	int n_checks = 0; // comparisons made
	int len; // cycles counted by the host
	word_t w; // word rebuilt from serial bits
	always #25 clk = ~clk;
	////////////////////////////////////////
	adc_control dut (.clk(clk), .rstn(rstn), .convert_start_n(cnv_n),
		.cs_n(cs_n), .rd_n(rd_n), .reset(rst_pin), .power_down(pd),
		.output_coding_select(coding), .serial_parallel_select(ser),
		.external_clock_select(ext), .sclk_in(sclk), .sar_code(code),
		.busy(busy), .sample_hold(hold), .low_power(lowp), .data_out(dout),
		.data_oe(doe), .serial_result_out(sdo), .serial_oe(soe),
		.sclk_out(sclk_o), .sclk_oe(sclk_en), .sync_out(sync_o),
		.incomplete_read_flag(flag));
	host_model host (.clk(clk), .busy(busy), .convert_start_n(cnv_n),
		.cs_n(cs_n), .rd_n(rd_n), .reset(rst_pin), .power_down(pd),
		.sclk_in(sclk));
	////////////////////////////////////////
	// expected word: two's complement just flips the top bit
	function automatic word_t coded(input word_t c, input logic ob);
		return ob ? c : c ^ 16'h8000;
	endfunction
	// compare and count; case inequality so unknowns never match
	task automatic check(input string what, input word_t exp,
		input word_t got);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	// one conversion from a clean start edge to busy fall
	task automatic conv(input word_t c, input logic ob);
		code = c;
		coding = ob;
		host.start_pulse();
		host.wait_ready(len);
	endtask
	// enables follow select and read only when both are low
	task automatic read_bus();
		host.set_sel(1'b0, 1'b0);
		check("data_oe", word_t'(!ser), word_t'(doe));
		check("serial_oe", word_t'(ser), word_t'(soe));
		host.set_sel(1'b1, 1'b0);
		check("oe_cs_high", 16'h0000, word_t'(doe | soe));
		host.set_sel(1'b0, 1'b1);
		check("oe_rd_high", 16'h0000, word_t'(doe | soe));
		host.set_sel(1'b1, 1'b1);
	endtask
	// verdict, the only place the run ends
	task automatic report_and_stop();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		coding = 1'b1;
		ser = 1'b0;
		ext = 1'b0;
		code = 16'h0000;
		void'($urandom(32'hca06be19));
		host.tick(10);
		rstn = 1'b1;
		check("oe_after_reset", 16'h0000, word_t'(doe));
		host.tick(25);
		// parallel conversions, midscale in both codings first
		for (int i = 0; i < 6; i++) begin
			conv(i < 2 ? 16'h8000 : word_t'($urandom), logic'(i % 2));
			check("busy_len", 16'h00a0, word_t'(len));
			check("data_out", coded(code, coding), dout);
			check("hold_after", 16'h0000, word_t'(hold));
			read_bus();
			host.tick(20);
		end
		// second edge while busy must not restart or stretch
		code = word_t'($urandom);
		host.start_pulse();
		host.tick(40);
		check("busy_mid", 16'h0001, word_t'(busy));
		check("hold_mid", 16'h0001, word_t'(hold));
		host.start_pulse();
		host.wait_ready(len);
		check("busy_len_edge", 16'h0077, word_t'(len));
		check("data_out_edge", coded(code, coding), dout);
		host.tick(40);
		check("no_restart", 16'h0000, word_t'(busy));
		// start held low through acquisition converts by itself
		conv(word_t'($urandom), 1'b1);
		host.set_start(1'b0);
		len = 0;
		while (busy !== 1'b1 && len < 40) begin
			host.tick(1);
			len++;
		end
		check("auto_start", 16'h0001, word_t'(len > 15 && len < 30));
		host.wait_ready(len);
		host.set_start(1'b1);
		check("auto_len", 16'h00a0, word_t'(len));
		// abort pin in mid-conversion
		host.tick(25);
		host.start_pulse();
		host.tick(30);
		host.pins(1'b1, 1'b0);
		check("busy_abort", 16'h0000, word_t'(busy));
		host.pins(1'b0, 1'b0);
		host.tick(25);
		// power-down lets the running conversion end, then blocks
		host.start_pulse();
		host.tick(20);
		host.pins(1'b0, 1'b1);
		host.wait_ready(len);
		check("pd_len", 16'h0088, word_t'(len));
		host.tick(25);
		check("low_power", 16'h0001, word_t'(lowp));
		host.start_pulse();
		check("pd_block", 16'h0000, word_t'(busy));
		host.pins(1'b0, 1'b0);
		host.tick(30);
		// serial slave: top bits 1000 so a stray shift shows
		ser = 1'b1;
		ext = 1'b1;
		conv({4'h8, 12'($urandom)}, 1'b1);
		repeat (3) host.sclk_pulse();
		check("gated_msb", word_t'(code[15]), word_t'(sdo));
		read_bus();
		check("slave_no_clk", 16'h0000, word_t'(sclk_en | sync_o));
		host.set_sel(1'b0, 1'b0);
		for (int b = 15; b >= 0; b--) begin
			w[b] = sdo;
			host.sclk_pulse();
		end
		check("serial_word", code, w);
		// read left a quarter done when the next result lands
		conv(~code, 1'b1);
		repeat (4) host.sclk_pulse();
		conv(~code, 1'b1);
		len = 0;
		while (flag !== 1'b1 && len < 4) begin
			host.tick(1);
			len++;
		end
		check("incomplete_flag", 16'h0001, word_t'(flag));
		check("new_msb", word_t'(code[15]), word_t'(sdo));
		// serial master: internal clock, bits taken on each rise
		ext = 1'b0;
		sclk_last = 1'b0;
		n_bits = 0;
		len = 0;
		while (n_bits < 16 && len < 200) begin
			host.tick(1);
			len++;
			if (sclk_o === 1'b1 && sclk_last === 1'b0) begin
				w = {w[14:0], sdo};
				n_bits++;
			end
			sclk_last = sclk_o;
		end
		check("master_oe", 16'h0001, word_t'(sclk_en & sync_o));
		check("master_word", code, w);
		host.tick(6);
		check("master_idle", 16'h0000, word_t'(sclk_o | sync_o));
		report_and_stop();
	end
	// watchdog: the run needs well under 6000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
